// >>> src/cfg_regs_pkg.sv
// constants for the interrupt pending-status and express capability register bank
package cfg_regs_pkg;
   localparam logic [11:0] OFS_MSG_CTL = 12'h048;
   localparam logic [11:0] OFS_MASK_64 = 12'h058;
   localparam logic [11:0] OFS_STAT_64 = 12'h05C;
   localparam logic [11:0] OFS_MASK_32 = 12'h054;
   localparam logic [11:0] OFS_STAT_32 = 12'h058;
   localparam logic [11:0] OFS_CAP_HDR = 12'h068;
   localparam logic [11:0] OFS_DEV_CAP = 12'h06C;
   localparam logic [11:0] OFS_DEV_STS_CTL = 12'h070;
   localparam logic [2:0] MME_ONE = 3'h0;
   localparam logic [2:0] MME_TWO = 3'h1;
   localparam logic [7:0] CAP_ID = 8'h10;
   localparam logic [7:0] CAP_NEXT = 8'h00;
   localparam logic [11:0] EXT_CAP_START = 12'h100;
   localparam logic [3:0] CAP_VERSION = 4'h2;
   localparam logic [3:0] PORT_TYPE_DEF = 4'h1;
   localparam logic [2:0] MPS_128 = 3'h0;
   localparam logic [2:0] MPS_256 = 3'h1;
   localparam logic [2:0] MRRS_DEF = 3'h2;
   localparam logic [2:0] MRRS_MAX = 3'h5;
   localparam logic [2:0] LAT_ANY = 3'h7;
   localparam logic [1:0] PWR_SCALE_1 = 2'h0;
   localparam logic [1:0] PWR_SCALE_0001 = 2'h3;
   // device capability fields
   localparam int DC_MPS_LSB = 0;
   localparam int DC_L0S_LSB = 6;
   localparam int DC_L1_LSB = 9;
   localparam int DC_RBER_BIT = 15;
   localparam int DC_PWR_VAL_LSB = 18;
   localparam int DC_PWR_SCL_LSB = 26;
   // header fields
   localparam int HDR_NEXT_LSB = 8;
   localparam int HDR_VER_LSB = 16;
   localparam int HDR_TYPE_LSB = 20;
   // device control/status and message control fields
   localparam int CTL_ERR_EN_LSB = 0;
   localparam int CTL_RLX_BIT = 4;
   localparam int CTL_MPS_LSB = 5;
   localparam int CTL_AUX_EN_BIT = 10;
   localparam int CTL_MRRS_LSB = 12;
   localparam int STS_ERR_LSB = 16;
   localparam int STS_AUX_DET_BIT = 20;
   localparam int MSGCTL_MME_LSB = 20;
   localparam int MSGCTL_64_BIT = 23;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   typedef enum logic [2:0] {
      SND_IDLE = 3'b001,
      SND_REQ = 3'b010,
      SND_DONE = 3'b100
   } send_state_t;
endpackage

// >>> src/express_cfg_regs.sv
// interrupt pending-status and express capability configuration registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RL1) message enable 001b two vectors, 000b one
// (RL2) single vector carries both groups, default
// (RL3) two vectors: first group 0, second 1
// (RL4) pending bit layout follows vector count
// (RL5) mask per bit; mask bit1 needs two vectors
// (RL6) pending bit clears once message sent
// (RL7) masked pending bits stay set
// (RL8) without 64-bit addressing, offsets shift down four
// (RL9) header id 10h, next 00h, extended at 100h
// (RL10) version 2h, port type reset-loaded default 1h
// (RL11) payload supported 001b by default
// (RL12) 5-bit tags, no phantoms, latency 111b, RBER
// (RL13) slot power value times scale code
// (RL14) four error reporting enables, default zero
// (RL15) error detected flags set always, write-1 clear
// (RL16) software keeps payload size within supported
// (RL17) controller read request size 128..4096, default 010b
// (RL18) bridge ports read request size reads zero
// (RL19) relaxed ordering link rw default 1, controller 0
// (RL20) sticky aux power enable, default zero
// (RL21) sticky aux power detected, default one
// (RL22) bit15, ext tag, phantom, no-snoop read zero
// (RL23) reserved fields read zero, ignore writes
module express_cfg_regs #(
   parameter bit IS_CONTROLLER = 1'b1,
   parameter bit ADDR64_CAP = 1'b1,
   parameter logic [2:0] MPS_SUPPORTED = cfg_regs_pkg::MPS_256,
   parameter logic [3:0] PORT_TYPE = cfg_regs_pkg::PORT_TYPE_DEF,
   parameter logic [7:0] PWR_LIMIT_VAL = 8'h00,
   parameter logic [1:0] PWR_LIMIT_SCALE = cfg_regs_pkg::PWR_SCALE_1
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic sticky_rst_n_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [11:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [3:0] cfg_be_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   input wire logic [2:0] msg_mme_i,
   input wire logic msg_64_cap_i,
   input wire logic first_irq_group_i,
   input wire logic second_irq_group_i,
   input wire logic msg_enable_i,
   input wire logic [3:0] err_detect_i,
   input wire logic aux_present_i,
   input wire logic msg_ack_i,
   output logic msg_req_o,
   output logic msg_vec_o,
   output logic [3:0] err_report_o,
   output logic aux_pwr_en_o,
   output logic [2:0] mps_o,
   output logic [2:0] mrrs_o
);
   typedef struct packed {
      logic [1:0] pend;
      logic [1:0] mask;
      logic [3:0] err_en;
      logic rlx;
      logic [2:0] mps;
      logic [2:0] mrrs;
      logic [3:0] err_det;
      logic [3:0] port_type;
      logic [31:0] rdata;
      logic rvalid;
      logic [3:0] err_rep;
      logic aux_sync1;
      logic aux_sync2;
   } regs_t;
   typedef struct packed {
      logic aux_en;
      logic aux_det;
   } sticky_t;

   regs_t cur_ff, nxt_ff;
   sticky_t stk_ff, nxt_stk;
   logic two_vec;
   logic [1:0] want;
   logic [1:0] sent;
   logic [11:0] ofs_mask;
   logic [11:0] ofs_stat;

   function automatic logic [2:0] keep_mrrs(input logic [2:0] v, input logic [2:0] old);
      keep_mrrs = (v > cfg_regs_pkg::MRRS_MAX) ? old : v;
   endfunction

   assign two_vec = (msg_mme_i == cfg_regs_pkg::MME_TWO); // [RL1] [RL2]
   assign ofs_mask = msg_64_cap_i ? cfg_regs_pkg::OFS_MASK_64 : cfg_regs_pkg::OFS_MASK_32; // [RL8]
   assign ofs_stat = msg_64_cap_i ? cfg_regs_pkg::OFS_STAT_64 : cfg_regs_pkg::OFS_STAT_32; // [RL8]
   // blocked when disabled or masked; pending stays set meanwhile
   assign want = msg_enable_i ? (cur_ff.pend & ~cur_ff.mask) : 2'h0; // [RL5] [RL7]

   vector_sender u_send (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .want_i(want),
      .msg_ack_i(msg_ack_i),
      .msg_req_o(msg_req_o),
      .msg_vec_o(msg_vec_o),
      .sent_o(sent)
   );

   function automatic logic [31:0] hdr_word(input logic [3:0] ptype);
      hdr_word = cfg_regs_pkg::ZERO_WORD;
      hdr_word[7:0] = cfg_regs_pkg::CAP_ID; // [RL9]
      hdr_word[cfg_regs_pkg::HDR_NEXT_LSB +: 8] = cfg_regs_pkg::CAP_NEXT; // [RL9]
      hdr_word[cfg_regs_pkg::HDR_VER_LSB +: 4] = cfg_regs_pkg::CAP_VERSION; // [RL10]
      hdr_word[cfg_regs_pkg::HDR_TYPE_LSB +: 4] = ptype; // [RL10]
   endfunction

   function automatic logic [31:0] devcap_word();
      devcap_word = cfg_regs_pkg::ZERO_WORD;
      // only 128 or 256 bytes are ever advertised
      devcap_word[cfg_regs_pkg::DC_MPS_LSB +: 3] =
         (MPS_SUPPORTED == cfg_regs_pkg::MPS_128) ? cfg_regs_pkg::MPS_128 : cfg_regs_pkg::MPS_256; // [RL11]
      devcap_word[cfg_regs_pkg::DC_L0S_LSB +: 3] = cfg_regs_pkg::LAT_ANY; // [RL12]
      devcap_word[cfg_regs_pkg::DC_L1_LSB +: 3] = cfg_regs_pkg::LAT_ANY; // [RL12]
      devcap_word[cfg_regs_pkg::DC_RBER_BIT] = 1'b1; // [RL12]
      devcap_word[cfg_regs_pkg::DC_PWR_VAL_LSB +: 8] = PWR_LIMIT_VAL; // [RL13]
      devcap_word[cfg_regs_pkg::DC_PWR_SCL_LSB +: 2] = PWR_LIMIT_SCALE; // [RL13]
   endfunction

   always_comb begin
      logic [31:0] rd;
      logic [31:0] w;
      logic hit_mask;
      logic hit_stat;
      logic hit_ctl;
      rd = cfg_regs_pkg::ZERO_WORD;
      w = cfg_wdata_i;
      nxt_ff = cur_ff;
      nxt_stk = stk_ff;
      hit_mask = (cfg_addr_i == ofs_mask);
      hit_stat = (cfg_addr_i == ofs_stat);
      hit_ctl = (cfg_addr_i == cfg_regs_pkg::OFS_DEV_STS_CTL);
      nxt_ff.aux_sync1 = aux_present_i;
      nxt_ff.aux_sync2 = cur_ff.aux_sync1;
      nxt_stk.aux_det = cur_ff.aux_sync2; // [RL21]
      // strap constant is taken on the first edge after release
      nxt_ff.port_type = PORT_TYPE; // [RL10]
      // software writes
      if (cfg_wr_i && cfg_be_i[0]) begin
         if (hit_mask) begin
            nxt_ff.mask[0] = w[0]; // [RL5]
            nxt_ff.mask[1] = two_vec & w[1]; // [RL5]
         end
         if (hit_stat) begin
            nxt_ff.pend[0] = w[0];
            nxt_ff.pend[1] = two_vec & w[1]; // [RL4]
         end
         if (hit_ctl) begin
            nxt_ff.err_en = w[cfg_regs_pkg::CTL_ERR_EN_LSB +: 4]; // [RL14]
            nxt_ff.rlx = IS_CONTROLLER ? 1'b0 : w[cfg_regs_pkg::CTL_RLX_BIT]; // [RL19]
            nxt_ff.mps[0] = w[cfg_regs_pkg::CTL_MPS_LSB]; // [RL16]
         end
      end
      if (cfg_wr_i && cfg_be_i[1] && hit_ctl) begin
         nxt_ff.mps[2:1] = 2'h0; // [RL16]
         nxt_stk.aux_en = w[cfg_regs_pkg::CTL_AUX_EN_BIT]; // [RL20]
         if (IS_CONTROLLER) begin
            nxt_ff.mrrs = keep_mrrs(w[cfg_regs_pkg::CTL_MRRS_LSB +: 3], cur_ff.mrrs); // [RL17]
         end
      end
      if (cfg_wr_i && cfg_be_i[2] && hit_ctl) begin
         nxt_ff.err_det = cur_ff.err_det & ~w[cfg_regs_pkg::STS_ERR_LSB +: 4]; // [RL15]
      end
      // hardware sets win over software clears
      nxt_ff.err_det = nxt_ff.err_det | err_detect_i; // [RL15]
      nxt_ff.err_rep = err_detect_i & cur_ff.err_en; // [RL14]
      nxt_ff.pend = nxt_ff.pend & ~sent; // [RL6]
      if (two_vec) begin
         nxt_ff.pend = nxt_ff.pend | {second_irq_group_i, first_irq_group_i}; // [RL3] [RL4]
      end else begin
         nxt_ff.pend[0] = nxt_ff.pend[0] | first_irq_group_i | second_irq_group_i; // [RL2] [RL4]
         nxt_ff.pend[1] = 1'b0; // [RL4]
         nxt_ff.mask[1] = 1'b0; // [RL5]
      end
      // reads; unmapped offsets and reserved bits return zero
      if (hit_mask) begin
         rd[1:0] = cur_ff.mask; // [RL5]
      end else if (hit_stat) begin
         rd[1:0] = cur_ff.pend; // [RL4]
      end else if (cfg_addr_i == cfg_regs_pkg::OFS_CAP_HDR) begin
         rd = hdr_word(cur_ff.port_type);
      end else if (cfg_addr_i == cfg_regs_pkg::OFS_DEV_CAP) begin
         rd = devcap_word();
      end else if (hit_ctl) begin
         rd[cfg_regs_pkg::CTL_ERR_EN_LSB +: 4] = cur_ff.err_en;
         rd[cfg_regs_pkg::CTL_RLX_BIT] = cur_ff.rlx;
         rd[cfg_regs_pkg::CTL_MPS_LSB +: 3] = cur_ff.mps;
         rd[cfg_regs_pkg::CTL_AUX_EN_BIT] = stk_ff.aux_en;
         rd[cfg_regs_pkg::CTL_MRRS_LSB +: 3] = cur_ff.mrrs; // [RL18]
         rd[cfg_regs_pkg::STS_ERR_LSB +: 4] = cur_ff.err_det;
         rd[cfg_regs_pkg::STS_AUX_DET_BIT] = stk_ff.aux_det; // [RL21]
      end
      nxt_ff.rdata = cfg_rd_i ? rd : cur_ff.rdata; // [RL22] [RL23]
      nxt_ff.rvalid = cfg_rd_i;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cur_ff.pend <= 2'h0;
         cur_ff.mask <= 2'h0;
         cur_ff.err_en <= 4'h0; // [RL14]
         cur_ff.rlx <= ~IS_CONTROLLER; // [RL19]
         cur_ff.mps <= cfg_regs_pkg::MPS_128;
         cur_ff.mrrs <= IS_CONTROLLER ? cfg_regs_pkg::MRRS_DEF : 3'h0; // [RL17] [RL18]
         cur_ff.err_det <= 4'h0;
         cur_ff.port_type <= cfg_regs_pkg::PORT_TYPE_DEF;
         cur_ff.rdata <= cfg_regs_pkg::ZERO_WORD;
         cur_ff.rvalid <= 1'b0;
         cur_ff.err_rep <= 4'h0;
         // synchroniser idles at present so the sticky detect flag does not dip after a function reset
         cur_ff.aux_sync1 <= 1'b1;
         cur_ff.aux_sync2 <= 1'b1;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // sticky state only clears on the fundamental reset
   always_ff @(posedge clk_i or negedge sticky_rst_n_i) begin
      if (!sticky_rst_n_i) begin
         stk_ff <= '{aux_en: 1'b0, aux_det: 1'b1}; // [RL20] [RL21]
      end else begin
         stk_ff <= nxt_stk;
      end
   end

   assign cfg_rdata_o = cur_ff.rdata;
   assign cfg_rvalid_o = cur_ff.rvalid;
   assign err_report_o = cur_ff.err_rep;
   assign aux_pwr_en_o = stk_ff.aux_en;
   assign mps_o = cur_ff.mps;
   assign mrrs_o = cur_ff.mrrs;
endmodule
`default_nettype wire

// >>> src/vector_sender.sv
// sequences interrupt message requests and reports which vector was sent
`timescale 1ns/1ps
`default_nettype none
module vector_sender (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [1:0] want_i,
   input wire logic msg_ack_i,
   output logic msg_req_o,
   output logic msg_vec_o,
   output logic [1:0] sent_o
);
   typedef struct packed {
      cfg_regs_pkg::send_state_t st;
      logic req;
      logic vec;
      logic [1:0] sent;
   } snd_t;
   snd_t cur_ff, nxt_ff;
   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.sent = 2'h0;
      case (cur_ff.st)
         cfg_regs_pkg::SND_IDLE: begin
            // vector 0 wins when both wait; vector 1 follows next round
            if (want_i != 2'h0) begin
               nxt_ff.vec = ~want_i[0];
               nxt_ff.req = 1'b1;
               nxt_ff.st = cfg_regs_pkg::SND_REQ;
            end
         end
         cfg_regs_pkg::SND_REQ: begin
            if (msg_ack_i) begin
               nxt_ff.req = 1'b0;
               nxt_ff.sent = cur_ff.vec ? 2'h2 : 2'h1;
               nxt_ff.st = cfg_regs_pkg::SND_DONE;
            end
         end
         cfg_regs_pkg::SND_DONE: nxt_ff.st = cfg_regs_pkg::SND_IDLE;
         default: begin
            nxt_ff.st = cfg_regs_pkg::SND_IDLE;
            nxt_ff.req = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cur_ff <= '{st: cfg_regs_pkg::SND_IDLE, req: 1'b0, vec: 1'b0, sent: 2'h0};
      end else begin
         cur_ff <= nxt_ff;
      end
   end
   assign msg_req_o = cur_ff.req;
   assign msg_vec_o = cur_ff.vec;
   assign sent_o = cur_ff.sent;
endmodule
`default_nettype wire

// >>> testbench/express_cfg_regs_props.sv
// assertions on the ports of the express config register bank
`timescale 1ns/1ps
`default_nettype none
module express_cfg_regs_props (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic cfg_rd_i,
   input wire logic [11:0] cfg_addr_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic cfg_rvalid_o,
   input wire logic [2:0] msg_mme_i,
   input wire logic [3:0] err_detect_i,
   input wire logic msg_ack_i,
   input wire logic msg_req_o,
   input wire logic msg_vec_o,
   input wire logic [3:0] err_report_o,
   input wire logic [2:0] mrrs_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   a_rd_answer: assert property (cfg_rvalid_o == $past(cfg_rd_i)) else $error("rvalid off");
   a_hdr_value: assert property (cfg_rd_i && cfg_addr_i == 12'h068 |=> cfg_rdata_o[23:0] == 24'h12_0010)
      else $error("header");
   a_cap_fields: assert property (cfg_rd_i && cfg_addr_i == 12'h06C |=> cfg_rdata_o[15:0] == 16'h8FC1)
      else $error("capability");
   a_err_cause: assert property ((err_report_o & ~$past(err_detect_i)) == 4'h0) else $error("report");
   a_req_steady: assert property (msg_req_o && !msg_ack_i |=> msg_req_o && $stable(msg_vec_o))
      else $error("request dropped");
   a_ack_clears: assert property (msg_req_o && msg_ack_i |=> !msg_req_o) else $error("request stuck");
   a_one_vector: assert property (msg_req_o && msg_mme_i != 3'h1 |-> !msg_vec_o) else $error("vector");
   a_mrrs_legal: assert property (mrrs_o <= 3'h5) else $error("read size");
endmodule
bind express_cfg_regs express_cfg_regs_props express_cfg_regs_props_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
   .msg_mme_i(msg_mme_i), .err_detect_i(err_detect_i), .msg_ack_i(msg_ack_i), .msg_req_o(msg_req_o),
   .msg_vec_o(msg_vec_o), .err_report_o(err_report_o), .mrrs_o(mrrs_o));
`default_nettype wire

// >>> testbench/msg_link_partner.sv
// link side that takes interrupt message requests and acknowledges them
`timescale 1ns/1ps
`default_nettype none
module msg_link_partner (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic msg_req_i,
   input wire logic [3:0] delay_i,
   output logic msg_ack_o
);
   logic [3:0] wait_ff;
   // a slow link keeps the request, and so the pending bit, up for delay_i extra cycles
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_ff <= 4'h0;
         msg_ack_o <= 1'b0;
      end else begin
         msg_ack_o <= msg_req_i && !msg_ack_o && wait_ff >= delay_i;
         wait_ff <= (msg_req_i && !msg_ack_o && wait_ff < delay_i) ? wait_ff + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the express config register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0, arst_n_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, cap64 = 1'b1, f_irq = 1'b0, s_irq = 1'b0;
   logic ack, req, vec, aux_o, rvalid, m_mps, m_aux;
   logic srst_n = 1'b0, aux_pin = 1'b1, msg_en = 1'b1, m_det = 1'b1;
   logic [11:0] addr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] be = 4'h0, err = 4'h0, rep, delay = 4'h0, m_en, m_sts, b;
   logic [2:0] mme = 3'h0, mps_o, mrrs_o, m_mrrs;
   int n_mismatch = 0, compares = 0, seed = 32'h7f374cde;
   always #5 clk_i = ~clk_i;
   express_cfg_regs #(.PWR_LIMIT_VAL(8'hA5), .PWR_LIMIT_SCALE(2'h3)) express_cfg_regs_inst (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .sticky_rst_n_i(srst_n), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(addr),
      .cfg_wdata_i(wdata), .cfg_be_i(be), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .msg_mme_i(mme),
      .msg_64_cap_i(cap64), .first_irq_group_i(f_irq), .second_irq_group_i(s_irq), .msg_enable_i(msg_en),
      .err_detect_i(err), .aux_present_i(aux_pin), .msg_ack_i(ack), .msg_req_o(req), .msg_vec_o(vec),
      .err_report_o(rep), .aux_pwr_en_o(aux_o), .mps_o(mps_o), .mrrs_o(mrrs_o));
   msg_link_partner msg_link_partner_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .msg_req_i(req),
      .delay_i(delay), .msg_ack_o(ack));
   task automatic finish_test();
      if (n_mismatch == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] exp70();
      return {11'h0, m_det, m_sts, 1'b0, m_mrrs, 1'b0, m_aux, 4'h0, m_mps, 1'b0, m_en};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] e);
      @(negedge clk_i);
      {cfg_wr_i, addr, wdata, be} = {1'b1, a, v, e};
      @(negedge clk_i);
      cfg_wr_i = 1'b0;
      if (a == 12'h070) begin
         if (e[0]) {m_en, m_mps} = {v[3:0], v[5]};
         if (e[1] && v[14:12] <= 3'h5) m_mrrs = v[14:12];
         if (e[1]) m_aux = v[10];
         if (e[2]) m_sts &= ~v[19:16];
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(negedge clk_i);
      {cfg_rd_i, addr} = {1'b1, a};
      @(negedge clk_i);
      cfg_rd_i = 1'b0;
      chk({31'h0, rvalid}, 32'h1);
      chk(rdata, exp);
   endtask
   task automatic chk_ctl();
      chk({25'h0, aux_o, mps_o, mrrs_o}, {25'h0, m_aux, 2'h0, m_mps, m_mrrs});
      rd(12'h070, exp70());
   endtask
   task automatic pulse(input logic f, input logic s, input logic [3:0] e);
      @(negedge clk_i);
      {f_irq, s_irq, err} = {f, s, e};
      @(negedge clk_i);
      {f_irq, s_irq, err} = 6'h0;
   endtask
   // both waits are bounded so a hung sender ends the run instead of stalling it
   task automatic wait_msg(input logic v);
      int i;
      for (i = 0; i < 40 && !req; i++) @(negedge clk_i);
      if (req !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
      chk({31'h0, vec}, {31'h0, v});
      for (i = 0; i < 40 && req; i++) @(negedge clk_i);
      if (req !== 1'b0) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   initial begin
      repeat (12) @(negedge clk_i);
      {arst_n_i, srst_n} = 2'h3;
      repeat (2) @(negedge clk_i);
      {m_en, m_sts, m_mrrs, m_mps, m_aux} = {8'h0, 3'h2, 2'h0};
      chk_ctl();
      rd(12'h068, 32'h0012_0010);
      rd(12'h06C, 32'h0C00_8FC1 | (32'hA5 << 18));
      wr(12'h0F0, 32'hFFFF_FFFF, 4'hF);
      rd(12'h0F0, 32'h0);
      wr(12'h070, 32'hFFFF_FF3F, 4'hF);
      chk_ctl();
      for (int c = 0; c < 8; c++) begin
         wr(12'h070, {17'h0, c[2:0], 12'h0}, 4'h2);
         chk_ctl();
      end
      wr(12'h070, 32'h0000_2005, 4'hF);
      for (int i = 0; i < 4; i++) begin
         pulse(1'b0, 1'b0, 4'h1 << i);
         chk({28'h0, rep}, {28'h0, m_en & (4'h1 << i)});
         m_sts |= 4'h1 << i;
         chk_ctl();
      end
      wr(12'h070, 32'h0001_2000, 4'h4);
      chk_ctl();
      repeat (8) begin
         d = $random(seed);
         b = d[7:4];
         d = $random(seed) & 32'hFFFF_FF3F;
         wr(12'h070, d, b);
         chk_ctl();
      end
      aux_pin = 1'b0;
      m_det = 1'b0;
      repeat (4) @(negedge clk_i);
      chk_ctl();
      aux_pin = 1'b1;
      m_det = 1'b1;
      repeat (4) @(negedge clk_i);
      wr(12'h070, 32'h0000_0400, 4'h2);
      arst_n_i = 1'b0;
      repeat (2) @(negedge clk_i);
      arst_n_i = 1'b1;
      repeat (2) @(negedge clk_i);
      {m_en, m_sts, m_mrrs, m_mps} = {8'h0, 3'h2, 1'b0};
      chk_ctl();
      wr(12'h058, 32'h3, 4'h1);
      rd(12'h058, 32'h1);
      pulse(1'b0, 1'b1, 4'h0);
      repeat (8) @(negedge clk_i);
      chk({31'h0, req}, 32'h0);
      rd(12'h05C, 32'h1);
      delay = 4'h6;
      msg_en = 1'b0;
      wr(12'h058, 32'h0, 4'h1);
      repeat (8) @(negedge clk_i);
      chk({31'h0, req}, 32'h0);
      rd(12'h05C, 32'h1);
      msg_en = 1'b1;
      rd(12'h05C, 32'h1);
      wait_msg(1'b0);
      rd(12'h05C, 32'h0);
      mme = 3'h1;
      pulse(1'b1, 1'b1, 4'h0);
      wait_msg(1'b0);
      wait_msg(1'b1);
      cap64 = 1'b0;
      wr(12'h054, 32'h2, 4'h1);
      pulse(1'b0, 1'b1, 4'h0);
      rd(12'h058, 32'h2);
      wr(12'h054, 32'h0, 4'h1);
      wait_msg(1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
